// ### hw/bgc_top.sv
`timescale 1ns/1ps
// bridge gate control with apb register access
module bgc_top #(
	parameter int AW = 8
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic [2:0]    hall_inputs,
	input  wire logic          sense_trip,
	input  wire logic          supply_uv,
	input  wire logic          over_temp,
	input  wire logic [2:0]    vds_high,
	input  wire logic [2:0]    boot_ok,
	output logic      [2:0]    high_gate_cmd,
	output logic      [2:0]    low_gate_cmd,
	input  wire logic          fault_i,
	output logic               fault_o,
	output logic               fault_oe,
	input  wire logic          speed_pulse_i,
	output logic               speed_pulse_o,
	output logic               speed_pulse_oe
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------

	logic [bgc_pkg::SY_W-1:0] raw_in;  // all asynchronous pins
	logic [bgc_pkg::SY_W-1:0] syn_in;  // after two flops

	assign raw_in = {speed_pulse_i, fault_i, boot_ok, vds_high,
	                 over_temp, supply_uv, sense_trip, hall_inputs};

	bgc_sync #(
		.W (bgc_pkg::SY_W)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (raw_in),
		.q       (syn_in)
	);

	logic [2:0] hall_s;   // hall code
	logic       trip_s;   // current comparator
	logic       uv_s;     // gate supply low
	logic       ot_s;     // thermal flag, hysteresis outside
	logic [2:0] vds_s;    // high-side vds above limit
	logic [2:0] boot_s;   // bootstrap charge current low
	logic       fpin_s;   // fault pin as seen on the wire
	logic       spin_s;   // speed pin as seen on the wire

	assign hall_s = syn_in[bgc_pkg::SY_HALL +: 3];
	assign trip_s = syn_in[bgc_pkg::SY_TRIP];
	assign uv_s   = syn_in[bgc_pkg::SY_UV];
	assign ot_s   = syn_in[bgc_pkg::SY_OT];
	assign vds_s  = syn_in[bgc_pkg::SY_VDS +: 3];
	assign boot_s = syn_in[bgc_pkg::SY_BOOT +: 3];
	assign fpin_s = syn_in[bgc_pkg::SY_FPIN];
	assign spin_s = syn_in[bgc_pkg::SY_SPIN];

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------

	logic [bgc_pkg::CTRL_W-1:0] ctrl_r;   // host control levels
	logic [bgc_pkg::TMR_W-1:0]  dead_r;   // dead time, cycles
	logic [bgc_pkg::TMR_W-1:0]  toff_r;   // off time, cycles
	logic [bgc_pkg::TMR_W-1:0]  blank_r;  // blank time, cycles

	logic chop;        // torque chop level
	logic slow_decay;  // 1 slow, 0 fast
	logic sre;         // sync_rectify_enable
	logic dir;         // rotation direction
	logic brake_n;     // active-low brake request
	logic br_reset;    // bridge reset, active high

	assign chop       = ctrl_r[bgc_pkg::CTRL_CHOP];
	assign slow_decay = ctrl_r[bgc_pkg::CTRL_SLOW];
	assign sre        = ctrl_r[bgc_pkg::CTRL_SRE];
	assign dir        = ctrl_r[bgc_pkg::CTRL_DIR];
	assign brake_n    = ctrl_r[bgc_pkg::CTRL_BRKN];
	assign br_reset   = ctrl_r[bgc_pkg::CTRL_RST];

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------

	logic setup_ph;   // first cycle of a transfer
	logic wr_acc;     // write takes effect
	logic sel_ctrl;
	logic sel_dead;
	logic sel_toff;
	logic sel_blank;
	logic sel_stat;
	logic mapped;

	assign setup_ph  = psel & ~penable;
	assign wr_acc    = psel & penable & pwrite;
	assign sel_ctrl  = (paddr == AW'(bgc_pkg::CTRL_OFF));
	assign sel_dead  = (paddr == AW'(bgc_pkg::DEAD_OFF));
	assign sel_toff  = (paddr == AW'(bgc_pkg::TOFF_OFF));
	assign sel_blank = (paddr == AW'(bgc_pkg::BLANK_OFF));
	assign sel_stat  = (paddr == AW'(bgc_pkg::STATUS_OFF));
	assign mapped    = sel_ctrl | sel_dead | sel_toff | sel_blank | sel_stat;

	// zero wait states; read data is staged in the setup cycle
	assign pready = 1'b1;

	// register writes; status is read-only, writes to it dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r  <= bgc_pkg::CTRL_RST_VAL;
			dead_r  <= bgc_pkg::DEAD_CYC;
			toff_r  <= bgc_pkg::TOFF_CYC;
			blank_r <= bgc_pkg::BLANK_CYC;
		end else if (wr_acc) begin
			if (sel_ctrl) begin
				ctrl_r <= pwdata[bgc_pkg::CTRL_W-1:0];
			end
			if (sel_dead) begin
				dead_r <= pwdata[bgc_pkg::TMR_W-1:0];
			end
			if (sel_toff) begin
				toff_r <= pwdata[bgc_pkg::TMR_W-1:0];
			end
			if (sel_blank) begin
				blank_r <= pwdata[bgc_pkg::TMR_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// commutation decode
	// ------------------------------------------------------------

	logic [2:0] fwd_hi;   // high select, direction set
	logic [2:0] fwd_lo;   // low select, direction set
	logic [2:0] hi_sel;   // one-hot high select
	logic [2:0] lo_sel;   // one-hot low select
	logic       hall_bad; // illegal hall code

	// bit0 phase a, bit1 b, bit2 c
	always_comb begin
		case (hall_s)
			3'b101: begin
				fwd_hi = 3'b001;
				fwd_lo = 3'b100;
			end
			3'b100: begin
				fwd_hi = 3'b010;
				fwd_lo = 3'b100;
			end
			3'b110: begin
				fwd_hi = 3'b010;
				fwd_lo = 3'b001;
			end
			3'b010: begin
				fwd_hi = 3'b100;
				fwd_lo = 3'b001;
			end
			3'b011: begin
				fwd_hi = 3'b100;
				fwd_lo = 3'b010;
			end
			3'b001: begin
				fwd_hi = 3'b001;
				fwd_lo = 3'b010;
			end
			default: begin
				// illegal codes select nothing
				fwd_hi = 3'b000;
				fwd_lo = 3'b000;
			end
		endcase
	end

	// reverse rotation swaps high and low of each step
	assign hi_sel   = dir ? fwd_hi : fwd_lo;
	assign lo_sel   = dir ? fwd_lo : fwd_hi;
	assign hall_bad = (hall_s == 3'b000) | (hall_s == 3'b111);

	// ------------------------------------------------------------
	// commutation step and speed pulse
	// ------------------------------------------------------------

	logic [2:0] hall_q;  // previous hall code
	logic       step;    // hall edge seen this cycle
	logic       speed_pulse_out_r;  // one-cycle speed pulse

	assign step = (hall_s != hall_q) & (hall_q != 3'b000); // reset code is never a step

	// leaving 000 is no commutation, so no false speed pulse after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hall_q <= 3'b000;
			speed_pulse_out_r <= 1'b0;
		end else begin
			hall_q <= hall_s;
			speed_pulse_out_r <= step;
		end
	end

	// ------------------------------------------------------------
	// faults
	// ------------------------------------------------------------

	logic short_r;    // latched lead short to ground
	logic short_set;  // high side on with high vds
	logic short_nxt;
	logic coast;      // full coast request
	logic fault;      // any fault active
	logic [2:0] hi_r; // high gate state
	logic [2:0] lo_r; // low gate state

	assign short_set = |(hi_r & vds_s);
	// set wins over a step clear; reset is safe as highs are off
	assign short_nxt = short_set | (short_r & ~(step | br_reset));

	// undervoltage is a plain level, so power-up is covered too
	assign coast = br_reset | hall_bad | uv_s | ot_s;
	// fault logic is cleared while reset is held
	assign fault = ~br_reset & (hall_bad | uv_s | ot_s | short_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_r <= 1'b0;
		end else begin
			short_r <= short_nxt;
		end
	end

	// ------------------------------------------------------------
	// fixed off-time current limit
	// ------------------------------------------------------------

	bgc_pkg::bgc_cl_e cl_r;    // limiter state
	bgc_pkg::bgc_cl_e cl_nxt;
	logic off_zero;    // off time elapsed
	logic blank_zero;  // blank time elapsed
	logic off_load;    // start off time
	logic blank_load;  // start blank time
	logic src_en;      // source-enable latch

	assign off_load   = (cl_r == bgc_pkg::CL_RUN) & trip_s;
	assign blank_load = (cl_r == bgc_pkg::CL_OFF) & off_zero;
	assign src_en     = (cl_r != bgc_pkg::CL_OFF);

	bgc_dncnt #(
		.W (bgc_pkg::TMR_W)
	) u_off (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (off_load),
		.en       (1'b1),
		.load_val (toff_r),
		.zero     (off_zero)
	);

	// blank counts only once a high side is really on
	bgc_dncnt #(
		.W (bgc_pkg::TMR_W)
	) u_blank (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (blank_load),
		.en       (|hi_r),
		.load_val (blank_r),
		.zero     (blank_zero)
	);

	// comparator is only looked at in the run state
	always_comb begin
		cl_nxt = cl_r;
		case (cl_r)
			bgc_pkg::CL_RUN: begin
				if (trip_s) begin
					cl_nxt = bgc_pkg::CL_OFF;
				end
			end
			bgc_pkg::CL_OFF: begin
				if (off_zero) begin
					cl_nxt = bgc_pkg::CL_BLANK;
				end
			end
			bgc_pkg::CL_BLANK: begin
				if (blank_zero) begin
					cl_nxt = bgc_pkg::CL_RUN;
				end
			end
			default: begin
				cl_nxt = bgc_pkg::CL_RUN;
			end
		endcase
		if (br_reset) begin
			cl_nxt = bgc_pkg::CL_RUN;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cl_r <= bgc_pkg::CL_RUN;
		end else begin
			cl_r <= cl_nxt;
		end
	end

	// ------------------------------------------------------------
	// desired gate pattern
	// ------------------------------------------------------------

	logic       drive;   // selected pair conducting
	logic [2:0] rc_hi;   // recirculation highs
	logic [2:0] rc_lo;   // recirculation lows
	logic [2:0] want_hi;
	logic [2:0] want_lo;

	assign drive = chop & src_en;

	// decay path; same table for chop-low and current trip
	always_comb begin
		if (!slow_decay && !sre) begin
			rc_hi = 3'b000;
			rc_lo = 3'b000;
		end else if (slow_decay && !sre) begin
			rc_hi = 3'b000;
			rc_lo = lo_sel;
		end else if (!slow_decay) begin
			rc_hi = lo_sel;
			rc_lo = hi_sel;
		end else begin
			rc_hi = 3'b000;
			rc_lo = lo_sel | hi_sel;
		end
	end

	// priority: coast, brake, pattern; short masks highs only
	assign want_hi = (coast | ~brake_n | short_r) ? 3'b000 :
	                 (drive ? hi_sel : rc_hi);
	assign want_lo = coast ? 3'b000 :
	                 (~brake_n ? 3'b111 : (drive ? lo_sel : rc_lo));

	// ------------------------------------------------------------
	// dead time and bootstrap hold-off
	// ------------------------------------------------------------

	logic       turn_off;  // any gate dropping now
	logic       dead_zero; // dead time over
	logic       can_on;    // turn-on allowed this cycle
	logic [2:0] hi_nxt;
	logic [2:0] lo_nxt;

	// turn-offs are immediate; turn-ons wait, never the reverse
	assign turn_off = |((hi_r & ~want_hi) | (lo_r & ~want_lo));
	assign can_on   = dead_zero & ~turn_off;

	bgc_dncnt #(
		.W (bgc_pkg::TMR_W)
	) u_dead (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (turn_off),
		.en       (1'b1),
		.load_val (dead_r),
		.zero     (dead_zero)
	);

	// partner of same phase must be off; high waits for bootstrap
	assign hi_nxt = want_hi & (hi_r | ({3{can_on}} & ~lo_r & boot_s));
	assign lo_nxt = want_lo & (lo_r | ({3{can_on}} & ~hi_r));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_r <= 3'b000;
			lo_r <= 3'b000;
		end else begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
		end
	end

	assign high_gate_cmd = hi_r;
	assign low_gate_cmd  = lo_r;

	// ------------------------------------------------------------
	// open-drain pins
	// ------------------------------------------------------------

	logic fault_r; // registered fault level

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= fault;
		end
	end

	// pin pulled high by fault; pulled low when healthy
	assign fault_o        = 1'b0;
	assign fault_oe       = ~fault_r;
	assign speed_pulse_o  = 1'b0;
	assign speed_pulse_oe = speed_pulse_out_r;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------

	logic [31:0] status;  // live block state
	logic [31:0] rd_mux;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	assign status = {13'h0000, spin_s, fpin_s, cl_r, lo_r, hi_r,
	                 fault, short_r, ot_s, uv_s, hall_bad, hall_s};

	// unmapped reads return zero
	always_comb begin
		if (sel_ctrl) begin
			rd_mux = {26'h0000000, ctrl_r};
		end else if (sel_dead) begin
			rd_mux = {16'h0000, dead_r};
		end else if (sel_toff) begin
			rd_mux = {16'h0000, toff_r};
		end else if (sel_blank) begin
			rd_mux = {16'h0000, blank_r};
		end else if (sel_stat) begin
			rd_mux = status;
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// staged at setup so the access phase sees stable data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r  <= rd_mux;
			pslverr_r <= ~mapped;
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & psel & penable;

endmodule

// ### hw/bgc_pkg.sv
package bgc_pkg;

	// apb register byte offsets
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] DEAD_OFF   = 8'h04;
	localparam logic [7:0] TOFF_OFF   = 8'h08;
	localparam logic [7:0] BLANK_OFF  = 8'h0c;
	localparam logic [7:0] STATUS_OFF = 8'h10;

	// control register field positions
	localparam int CTRL_CHOP  = 0;
	localparam int CTRL_SLOW  = 1;
	localparam int CTRL_SRE   = 2;
	localparam int CTRL_DIR   = 3;
	localparam int CTRL_BRKN  = 4;
	localparam int CTRL_RST   = 5;
	localparam int CTRL_W     = 6;

	// control after reset: bridge held in reset, chop low
	localparam logic [5:0] CTRL_RST_VAL = 6'h3e;

	// timer bases
	localparam int CLK_NS     = 100;
	localparam int DEAD_NS    = 100;
	localparam int TOFF_NS    = 10000;
	localparam int BLANK_NS   = 1000;
	localparam int TMR_W      = 16;

	// least times round up to whole cycles
	localparam logic [15:0] DEAD_CYC  = 16'((DEAD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] TOFF_CYC  = 16'((TOFF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] BLANK_CYC = 16'((BLANK_NS + CLK_NS - 1) / CLK_NS);

	// synchroniser layout of pin inputs
	localparam int SY_HALL  = 0;
	localparam int SY_TRIP  = 3;
	localparam int SY_UV    = 4;
	localparam int SY_OT    = 5;
	localparam int SY_VDS   = 6;
	localparam int SY_BOOT  = 9;
	localparam int SY_FPIN  = 12;
	localparam int SY_SPIN  = 13;
	localparam int SY_W     = 14;

	// current limit states, one-hot
	typedef enum logic [2:0] {
		CL_RUN   = 3'b001,
		CL_OFF   = 3'b010,
		CL_BLANK = 3'b100
	} bgc_cl_e;

endpackage

// ### hw/bgc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bus of unrelated levels
module bgc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r; // first stage, read only by q

	// bits are independent levels, no word coherence implied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ### hw/bgc_dncnt.sv
`timescale 1ns/1ps
// loadable down-counter, sticks at zero
module bgc_dncnt #(
	parameter int W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         load,
	input  wire logic         en,
	input  wire logic [W-1:0] load_val,
	output logic              zero
);

	logic [W-1:0] cnt_r; // remaining cycles

	// load wins over counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (en && cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign zero = (cnt_r == '0);

endmodule

// ### tb/bgc_monitor.sv
`timescale 1ns/1ps
// port-level checks on gate, fault and apb outputs
module bgc_monitor (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pslverr,
	input wire logic [2:0] hall_inputs,
	input wire logic       supply_uv,
	input wire logic       over_temp,
	input wire logic [2:0] vds_high,
	input wire logic [2:0] high_gate_cmd,
	input wire logic [2:0] low_gate_cmd,
	input wire logic       fault_oe
);
	logic [5:0] g_q_r;    // gates one cycle ago
	logic [5:0] g;        // all six gates
	logic       g_off;    // some gate just dropped
	logic       g_on;     // some gate just rose
	logic       hall_bad; // code with no commutation step

	default clocking mon_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign g        = {high_gate_cmd, low_gate_cmd};
	assign g_off    = |(g_q_r & ~g);
	assign g_on     = |(g & ~g_q_r);
	assign hall_bad = (hall_inputs == 3'h0) || (hall_inputs == 3'h7);

	// history of the gates, cleared with the bridge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g_q_r <= 6'h00;
		end else begin
			g_q_r <= g;
		end
	end

	// three samples cover two sync flops and the gate register
	no_overlap_a: assert property ((high_gate_cmd & low_gate_cmd) == 3'h0)
		else $error("both transistors of a phase on");
	dead_gap_a: assert property (g_off |-> !g_on ##1 !g_on)
		else $error("turn-on inside dead time");
	hall_coast_a: assert property (hall_bad [*3] |=> g == 6'h00)
		else $error("bad hall code did not coast");
	uv_coast_a: assert property (supply_uv [*3] |=> g == 6'h00)
		else $error("undervoltage did not coast");
	hot_coast_a: assert property (over_temp [*3] |=> g == 6'h00)
		else $error("over-temperature did not coast");
	fault_highs_a: assert property (!fault_oe |-> high_gate_cmd == 3'h0)
		else $error("high side on during a fault");
	short_off_a: assert property ((|(high_gate_cmd & vds_high)) [*3] |-> ##[1:2] high_gate_cmd == 3'h0)
		else $error("shorted lead kept high side on");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("slave error outside access phase");

	cover property (g_off ##2 g_on);
	cover property (!fault_oe);
	cover property (pslverr);
endmodule

// ### tb/bgc_bridge_model.sv
`timescale 1ns/1ps
// external bridge: high-side vds, bootstrap monitor, pulled-up pins
module bgc_bridge_model (
	input wire logic       short_on,
	input wire logic       boot_hold,
	input wire logic [2:0] high_gate_cmd,
	input wire logic       fault_o,
	input wire logic       fault_oe,
	input wire logic       speed_pulse_o,
	input wire logic       speed_pulse_oe,
	output logic     [2:0] vds_high,
	output logic     [2:0] boot_ok,
	output logic           fault_i,
	output logic           speed_pulse_i
);
	// a grounded lead leaves the supply across every high side that is on
	assign vds_high      = high_gate_cmd & {3{short_on}};
	// charge current stays above limit while the bench holds it
	assign boot_ok       = {3{~boot_hold}};
	// open-drain pins: released means pulled high
	assign fault_i       = fault_oe ? fault_o : 1'b1;
	assign speed_pulse_i = speed_pulse_oe ? speed_pulse_o : 1'b1;
endmodule

// ### tb/bgc_top_tb.sv
`timescale 1ns/1ps
// four-state compare, counted
`define CHK(g, e) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) begin \
			n_mismatch++; \
			$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); \
		end \
	end
module bgc_top_tb;
	logic        pclk        = 1'b0;
	logic        presetn     = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0;
	logic [2:0]  hall_inputs = 3'h5;
	logic        sense_trip  = 1'b0;
	logic        supply_uv   = 1'b0;
	logic        over_temp   = 1'b0;
	logic        short_on    = 1'b0;
	logic        boot_hold   = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  vds_high;
	logic [2:0]  boot_ok;
	logic [2:0]  high_gate_cmd;
	logic [2:0]  low_gate_cmd;
	logic        fault_i;
	logic        fault_o;
	logic        fault_oe;
	logic        speed_pulse_i;
	logic        speed_pulse_o;
	logic        speed_pulse_oe;
	logic [31:0] rdata;                                          // last read word
	logic        rerr;                                           // last slave error
	logic [5:0]  sel_w;                                          // selected {high, low}
	logic [31:0] rst_val [4] = '{32'h3e, 32'h1, 32'h64, 32'ha}; // timer and control reset values
	int          n_mismatch  = 0;
	int          cmp_count   = 0;
	int          n;

	// 100 ns clock
	always #50 pclk = ~pclk;

	bgc_top #(.AW(8)) bgc_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hall_inputs(hall_inputs), .sense_trip(sense_trip), .supply_uv(supply_uv),
		.over_temp(over_temp), .vds_high(vds_high), .boot_ok(boot_ok),
		.high_gate_cmd(high_gate_cmd), .low_gate_cmd(low_gate_cmd), .fault_i(fault_i),
		.fault_o(fault_o), .fault_oe(fault_oe), .speed_pulse_i(speed_pulse_i),
		.speed_pulse_o(speed_pulse_o), .speed_pulse_oe(speed_pulse_oe)
	);

	bgc_bridge_model bgc_bridge_model_inst (
		.short_on(short_on), .boot_hold(boot_hold), .high_gate_cmd(high_gate_cmd),
		.fault_o(fault_o), .fault_oe(fault_oe), .speed_pulse_o(speed_pulse_o),
		.speed_pulse_oe(speed_pulse_oe), .vds_high(vds_high), .boot_ok(boot_ok),
		.fault_i(fault_i), .speed_pulse_i(speed_pulse_i)
	);

	// one apb transfer; data and error taken at the completing edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// long enough for sync, dead time and gate register
	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask

	// commutation step, {high, low}; first sensor in bit 2; reversed direction swaps the pair
	function automatic logic [5:0] sel(input logic [2:0] h, input logic dir);
		logic [5:0] v;
		case (h)
			3'h5: v = 6'b001_100;
			3'h4: v = 6'b010_100;
			3'h6: v = 6'b010_001;
			3'h2: v = 6'b100_001;
			3'h3: v = 6'b100_010;
			3'h1: v = 6'b001_010;
			default: v = 6'h00;
		endcase
		return dir ? v : {v[2:0], v[5:3]};
	endfunction

	// gates for chop level and decay setting m = {rectify, slow, chop}
	function automatic logic [5:0] exp_gates(input logic [5:0] hl, input logic [2:0] m);
		if (m[0]) begin
			return hl;
		end
		case (m[2:1])
			2'b00: return 6'h00;
			2'b01: return {3'h0, hl[2:0]};
			2'b10: return {hl[2:0], hl[5:3]};
			default: return {3'h0, hl[5:3] | hl[2:0]};
		endcase
	endfunction

	task automatic give_verdict();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard, well beyond the thirteen hundred or so cycles the tests need
	initial begin
		#2_000_000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		`CHK({high_gate_cmd, low_gate_cmd, fault_oe}, 7'h01);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK(rdata, rst_val[i]);
		end
		apb(1'b0, 8'h14, 32'h0);
		`CHK({rerr, rdata}, 33'h1_0000_0000);
		apb(1'b1, bgc_pkg::DEAD_OFF, 32'hffff_0001);
		apb(1'b0, bgc_pkg::DEAD_OFF, 32'h0);
		`CHK(rdata, 32'h1);
		apb(1'b1, bgc_pkg::TOFF_OFF, 32'h5);
		apb(1'b1, bgc_pkg::BLANK_OFF, 32'h8);
		// every step, both directions, every chop and decay setting
		for (int d = 0; d < 2; d++) begin
			for (int h = 1; h < 7; h++) begin
				hall_inputs <= 3'(h);
				sel_w = sel(3'(h), d[0]);
				for (int m = 0; m < 8; m++) begin
					apb(1'b1, bgc_pkg::CTRL_OFF, {28'h1, d[0], m[2:0]});
					settle();
					`CHK({high_gate_cmd, low_gate_cmd}, exp_gates(sel_w, m[2:0]));
				end
			end
		end
		hall_inputs <= 3'h5;
		apb(1'b1, bgc_pkg::CTRL_OFF, 32'h09);
		settle();
		`CHK({high_gate_cmd, low_gate_cmd}, 6'h07);
		apb(1'b1, bgc_pkg::CTRL_OFF, 32'h29);
		settle();
		`CHK({high_gate_cmd, low_gate_cmd}, 6'h00);
		apb(1'b1, bgc_pkg::CTRL_OFF, 32'h19);
		// bad codes, undervoltage, heat: coast, then recover unaided
		for (int k = 0; k < 4; k++) begin
			hall_inputs <= (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'h5;
			supply_uv   <= (k == 2);
			over_temp   <= (k == 3);
			settle();
			`CHK({high_gate_cmd, low_gate_cmd, fault_i}, 7'h01);
			hall_inputs <= 3'h5;
			supply_uv   <= 1'b0;
			over_temp   <= 1'b0;
			settle();
			`CHK({high_gate_cmd, low_gate_cmd, fault_i}, 7'h18);
		end
		// short stays latched after the lead recovers
		short_on <= 1'b1;
		settle();
		short_on <= 1'b0;
		settle();
		`CHK({high_gate_cmd, low_gate_cmd, fault_i}, 7'h09);
		// status is read-only: a write is dropped without an error
		apb(1'b1, bgc_pkg::STATUS_OFF, 32'h0);
		`CHK(rerr, 1'b0);
		apb(1'b0, bgc_pkg::STATUS_OFF, 32'h0);
		`CHK(rdata[6], 1'b1);
		// speed pulse: two sync flops, step, then one registered cycle
		hall_inputs <= 3'h4;
		for (n = 0; n < 8 && speed_pulse_oe !== 1'b1; n++) @(posedge pclk);
		`CHK(n, 4);
		@(posedge pclk);
		`CHK(speed_pulse_oe, 1'b0);
		settle();
		`CHK({high_gate_cmd, low_gate_cmd, fault_i}, 7'h28);
		short_on <= 1'b1;
		settle();
		short_on <= 1'b0;
		apb(1'b1, bgc_pkg::CTRL_OFF, 32'h39);
		apb(1'b1, bgc_pkg::CTRL_OFF, 32'h19);
		settle();
		`CHK({high_gate_cmd, low_gate_cmd, fault_i}, 7'h28);
		// high side waits for bootstrap charge, without a fault
		boot_hold   <= 1'b1;
		hall_inputs <= 3'h5;
		settle();
		`CHK({high_gate_cmd, low_gate_cmd, fault_i}, 7'h08);
		boot_hold <= 1'b0;
		settle();
		`CHK({high_gate_cmd, low_gate_cmd}, 6'h0c);
		// current trip, off time, then a trip hidden by blanking
		sense_trip <= 1'b1;
		repeat (3) @(posedge pclk);
		sense_trip <= 1'b0;
		for (n = 0; n < 20 && high_gate_cmd !== 3'h0; n++) @(posedge pclk);
		`CHK({high_gate_cmd, low_gate_cmd}, 6'h00);
		for (n = 0; n < 20 && high_gate_cmd === 3'h0; n++) @(posedge pclk);
		`CHK(n >= 4 && n <= 7, 1'b1);
		sense_trip <= 1'b1;
		repeat (3) @(posedge pclk);
		sense_trip <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK({high_gate_cmd, low_gate_cmd}, 6'h0c);
		// reset in mid-run drops gates at once
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK({high_gate_cmd, low_gate_cmd, fault_oe}, 7'h01);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, bgc_pkg::CTRL_OFF, 32'h0);
		`CHK(rdata, 32'h3e);
		give_verdict();
	end
endmodule

bind bgc_top bgc_monitor bgc_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
	.hall_inputs(hall_inputs), .supply_uv(supply_uv), .over_temp(over_temp),
	.vds_high(vds_high), .high_gate_cmd(high_gate_cmd), .low_gate_cmd(low_gate_cmd),
	.fault_oe(fault_oe)
);
